// ---- inc/dbc_map.svh ----
// Register offsets, field positions, reset values and timing figures.
`ifndef DBC_MAP_SVH
`define DBC_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DBC_ADDR_CTRL 4'h0
`define DBC_ADDR_BRT 4'h1
`define DBC_ADDR_DUTY 4'h2
`define DBC_ADDR_LEVEL 4'h3
`define DBC_ADDR_STATUS 4'h4
// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define DBC_F_MODE 1:0
`define DBC_F_SLOPE 4:2
`define DBC_F_HYBRID 5
`define DBC_F_SWITCH 8:6
`define DBC_F_GAIN 11:9
`define DBC_F_PLL 12
`define DBC_CTRL_RST 16'h0000
`define DBC_BRT_RST 16'h0000
`define DBC_FULL 16'hFFFF
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DBC_CLK_KHZ 100000
`define DBC_DET_KHZ 10000
`define DBC_DIR_KHZ 5000
`define DBC_US_KHZ 1000
`define DBC_TIMEOUT_MS 24
`define DBC_DIR_STAGES 6
`define DBC_DIV_STEPS 5'h10
`define DBC_GAIN_SHIFT 10
// ----------------------------------------------------------------
// Slope times in ms, switch points, reciprocals and gains
// ----------------------------------------------------------------
`define DBC_SLOPE_MS '{0, 1, 2, 52, 105, 210, 315, 511}
`define DBC_SWITCH '{16'h8000, 16'h6800, 16'h5000, 16'h4000, \
  16'h3800, 16'h3000, 16'h2800, 16'h2000}
`define DBC_RECIP '{20'h20000, 20'h27627, 20'h33333, 20'h40000, \
  20'h49249, 20'h55555, 20'h66666, 20'h80000}
`define DBC_GAIN '{11'h400, 11'h418, 11'h430, 11'h448, 11'h460, \
  11'h478, 11'h490, 11'h4A8}
`endif

// ---- inc/dbc_pkg.sv ----
// Types shared by the display brightness control block.
package dbc_pkg;
  typedef enum logic [1:0] {
    MODE_DUTY = 2'h0,
    MODE_REG = 2'h1,
    MODE_PROD = 2'h2,
    MODE_DIRECT = 2'h3
  } dbc_mode_type;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'h0,
    DIV_RUN = 2'h1,
    DIV_DONE = 2'h3
  } dbc_div_state_type;

  typedef struct packed {
    logic pll_en;
    logic [2:0] gain_sel;
    logic [2:0] switch_sel;
    logic hybrid_en;
    logic [2:0] slope_sel;
    dbc_mode_type mode;
  } dbc_cfg_type;
endpackage

// ---- hw/dbc_top.sv ----
// Display brightness control: source select, duty detect, slope, hybrid.
//
// Contract
// [R1] Two-bit source select field written by software picks brightness source.
// [R2] Codes: 00 input duty, 01 register, 10 product, 11 direct pass.
// [R3] Input duty mode measures pin duty as 16 bits and drives output duty.
// [R4] Input period runs from one rising edge to the next.
// [R5] Detector samples input at 10 MHz; resolution is sample rate over input.
// [R6] Timeout 24 ms after last rise; steady level gives 0% or 100%.
// [R7] Host keeps each input high and low phase at least 400 ns.
// [R8] Register mode takes output duty from the 16-bit brightness register.
// [R9] Product mode multiplies measured duty by brightness register value.
// [R10] Direct mode copies input, sampled at 5 MHz or the PLL clock.
// [R11] Direct output edge lags input edge by five to six sample clocks.
// [R12] Direct mode bypasses stagger, slope, dither, hybrid and thermal limit.
// [R13] Direct input below 100%; at 100% adaptive boost control switches off.
// [R14] Slope ramps old to new brightness, same time up and down.
// [R15] Slope codes 000 off, then 1, 2, 52, 105, 210, 315, 511 ms.
// [R16] Hybrid bit set: PWM dimming low range, current dimming high range.
// [R17] Switch point codes give 50.0 down to 12.5 percent brightness.
// [R18] Gain codes give slope gain 1.000 up to 1.164.
// [R19] Software sets hybrid display current from max, scale, gain, switch.
// [R20] Below switch point duty scales to full; above, current rises linearly.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "dbc_map.svh"
module dbc_top import dbc_pkg::*; #(
  parameter int P_TIMEOUT_TICKS = `DBC_TIMEOUT_MS * `DBC_DET_KHZ
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Pins and clock ticks
  input wire logic i_pwm_in,
  input wire logic i_pll_tick,
  // Brightness results
  output logic [15:0] o_led_duty,
  output logic [15:0] o_led_current,
  output logic o_direct_pwm,
  output logic o_direct_mode,
  output logic o_adaptive_off
);
  localparam int CW = $clog2(P_TIMEOUT_TICKS + 1);
  localparam int DET_DIV = `DBC_CLK_KHZ / `DBC_DET_KHZ;
  localparam int DIR_DIV = `DBC_CLK_KHZ / `DBC_DIR_KHZ;
  localparam int US_DIV = `DBC_CLK_KHZ / `DBC_US_KHZ;
  localparam int TW = 7;
  if (P_TIMEOUT_TICKS < 2 || CW > 24) begin : g_bad
    $error("Timeout count out of range.");
  end
  function automatic logic [31:0] slope_inc(input logic [2:0] sel);
    int ms [8];
    ms = `DBC_SLOPE_MS;
    if (ms[sel] == 0) begin
      slope_inc = 32'hFFFF_FFFF;
    end else begin
      slope_inc = 32'(64'h1_0000_0000 / 64'(ms[sel] * `DBC_US_KHZ));
    end
  endfunction
  function automatic logic [15:0] switch_pt(input logic [2:0] sel);
    logic [15:0] t [8];
    t = `DBC_SWITCH;
    switch_pt = t[sel];
  endfunction
  function automatic logic [19:0] recip(input logic [2:0] sel);
    logic [19:0] t [8];
    t = `DBC_RECIP;
    recip = t[sel];
  endfunction
  function automatic logic [10:0] gain(input logic [2:0] sel);
    logic [10:0] t [8];
    t = `DBC_GAIN;
    gain = t[sel];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and tick generators
  // ----------------------------------------------------------------
  logic sync1_q, sync2_q;
  logic [TW-1:0] det_cnt_q, dir_cnt_q, us_cnt_q, det_cnt_d, dir_cnt_d;
  logic [TW-1:0] us_cnt_d;
  logic det_tick_q, dir_tick_q, us_tick_q, det_tick_d, dir_tick_d, us_tick_d;
  always_comb begin
    det_tick_d = (det_cnt_q == TW'(DET_DIV - 1)); // R5
    dir_tick_d = (dir_cnt_q == TW'(DIR_DIV - 1));
    us_tick_d = (us_cnt_q == TW'(US_DIV - 1));
    det_cnt_d = det_tick_d ? '0 : det_cnt_q + 1'b1;
    dir_cnt_d = dir_tick_d ? '0 : dir_cnt_q + 1'b1;
    us_cnt_d = us_tick_d ? '0 : us_cnt_q + 1'b1;
  end
  always_ff @(posedge i_clock) begin
    sync1_q <= i_pwm_in;
    sync2_q <= sync1_q;
    if (i_srst) begin
      det_cnt_q <= '0;
      dir_cnt_q <= '0;
      us_cnt_q <= '0;
      det_tick_q <= 1'b0;
      dir_tick_q <= 1'b0;
      us_tick_q <= 1'b0;
    end else begin
      det_cnt_q <= det_cnt_d;
      dir_cnt_q <= dir_cnt_d;
      us_cnt_q <= us_cnt_d;
      det_tick_q <= det_tick_d;
      dir_tick_q <= dir_tick_d;
      us_tick_q <= us_tick_d;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  dbc_cfg_type cfg_q, cfg_d;
  logic [15:0] brt_q, brt_d, rdata_d, duty_q, duty_d, level;
  logic tout_q;
  always_comb begin
    cfg_d = cfg_q;
    brt_d = brt_q;
    rdata_d = '0;
    if (i_wr && i_addr == `DBC_ADDR_CTRL) begin
      cfg_d = dbc_cfg_type'(i_wdata[`DBC_F_PLL:0]); // R1
    end
    if (i_wr && i_addr == `DBC_ADDR_BRT) begin
      brt_d = i_wdata;
    end
    if (i_rd) begin
      case (i_addr)
        `DBC_ADDR_CTRL: rdata_d = 16'(cfg_q);
        `DBC_ADDR_BRT: rdata_d = brt_q;
        `DBC_ADDR_DUTY: rdata_d = duty_q;
        `DBC_ADDR_LEVEL: rdata_d = level;
        `DBC_ADDR_STATUS: rdata_d = {14'h0000, o_adaptive_off, tout_q};
        default: rdata_d = '0;
      endcase
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cfg_q <= dbc_cfg_type'(`DBC_CTRL_RST);
      brt_q <= `DBC_BRT_RST;
      o_rdata <= '0;
    end else begin
      cfg_q <= cfg_d;
      brt_q <= brt_d;
      o_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Duty detector with divider
  // ----------------------------------------------------------------
  dbc_div_state_type st_q, st_d;
  logic prev_q, prev_d, tout_d;
  logic [CW-1:0] per_q, per_d, hi_q, hi_d, dper_q, dper_d;
  logic [CW:0] rem_q, rem_d, rem2;
  logic [16:0] quot_q, quot_d;
  logic [4:0] step_q, step_d;
  always_comb begin
    st_d = st_q;
    prev_d = prev_q;
    per_d = per_q;
    hi_d = hi_q;
    tout_d = tout_q;
    dper_d = dper_q;
    rem_d = rem_q;
    quot_d = quot_q;
    step_d = step_q;
    duty_d = duty_q;
    rem2 = {rem_q[CW-1:0], 1'b0};
    if (det_tick_q) begin
      prev_d = sync2_q;
      if (sync2_q && !prev_q) begin
        if (!tout_q && per_q != '0 && st_q == DIV_IDLE) begin
          st_d = DIV_RUN; // R4
          dper_d = per_q;
          rem_d = {1'b0, hi_q};
          quot_d = '0;
          step_d = '0;
        end
        per_d = CW'(1);
        hi_d = CW'(1);
        tout_d = 1'b0;
      end else if (per_q == CW'(P_TIMEOUT_TICKS - 1) || tout_q) begin
        tout_d = 1'b1; // R6
        duty_d = sync2_q ? `DBC_FULL : '0;
      end else begin
        per_d = per_q + 1'b1;
        hi_d = hi_q + CW'(sync2_q);
      end
    end
    case (st_q)
      DIV_IDLE: st_d = st_d;
      DIV_RUN: begin
        if (rem2 >= {1'b0, dper_q}) begin
          rem_d = rem2 - {1'b0, dper_q};
          quot_d = {quot_q[15:0], 1'b1};
        end else begin
          rem_d = rem2;
          quot_d = {quot_q[15:0], 1'b0};
        end
        step_d = step_q + 1'b1;
        if (step_q == `DBC_DIV_STEPS - 5'h01) begin
          st_d = DIV_DONE;
        end
      end
      DIV_DONE: begin
        st_d = DIV_IDLE;
        if (!tout_q) begin
          duty_d = quot_q[16] ? `DBC_FULL : quot_q[15:0]; // R3
        end
      end
      default: st_d = DIV_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_q <= DIV_IDLE;
      prev_q <= 1'b0;
      per_q <= '0;
      hi_q <= '0;
      tout_q <= 1'b0;
      dper_q <= '0;
      rem_q <= '0;
      quot_q <= '0;
      step_q <= '0;
      duty_q <= '0;
    end else begin
      st_q <= st_d;
      prev_q <= prev_d;
      per_q <= per_d;
      hi_q <= hi_d;
      tout_q <= tout_d;
      dper_q <= dper_d;
      rem_q <= rem_d;
      quot_q <= quot_d;
      step_q <= step_d;
      duty_q <= duty_d;
    end
  end

  // ----------------------------------------------------------------
  // Source select, slope and hybrid dimming
  // ----------------------------------------------------------------
  logic [31:0] prod, cur_q, cur_d, inc;
  logic [15:0] tgt, led_duty_d, led_cur_d;
  logic [35:0] scaled;
  logic [26:0] cur_gain;
  logic direct;
  assign level = cur_q[31:16];
  always_comb begin
    direct = (cfg_q.mode == MODE_DIRECT);
    prod = duty_q * brt_q;
    case (cfg_q.mode) // R2
      MODE_DUTY: tgt = duty_q; // R3
      MODE_REG: tgt = brt_q; // R8
      MODE_PROD: tgt = prod[31:16]; // R9
      default: tgt = level;
    endcase
    inc = slope_inc(cfg_q.slope_sel);
    cur_d = cur_q;
    if (cfg_q.slope_sel == 3'h0) begin
      cur_d = {tgt, 16'h0000}; // R15
    end else if (us_tick_q && !direct) begin
      if ({tgt, 16'h0000} > cur_q) begin // R14
        cur_d = ({tgt, 16'h0000} - cur_q > inc) ? cur_q + inc : {tgt, 16'h0};
      end else if ({tgt, 16'h0000} < cur_q) begin
        cur_d = (cur_q - {tgt, 16'h0000} > inc) ? cur_q - inc : {tgt, 16'h0};
      end
    end
    scaled = level * recip(cfg_q.switch_sel);
    cur_gain = (level - switch_pt(cfg_q.switch_sel)) * gain(cfg_q.gain_sel);
    led_duty_d = level;
    led_cur_d = `DBC_FULL;
    if (direct) begin
      led_duty_d = '0; // R12
    end else if (cfg_q.hybrid_en) begin // R16
      if (level < switch_pt(cfg_q.switch_sel)) begin
        led_duty_d = |scaled[35:32] ? `DBC_FULL : scaled[31:16]; // R20
        led_cur_d = '0;
      end else begin
        led_duty_d = `DBC_FULL; // R17
        led_cur_d = |cur_gain[26:26] ? `DBC_FULL : cur_gain[25:10]; // R18
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cur_q <= '0;
      o_led_duty <= '0;
      o_led_current <= '0;
    end else begin
      cur_q <= cur_d;
      o_led_duty <= led_duty_d;
      o_led_current <= led_cur_d;
    end
  end

  // ----------------------------------------------------------------
  // Direct pass-through
  // ----------------------------------------------------------------
  logic [`DBC_DIR_STAGES-1:0] dsh_q, dsh_d;
  logic dir_smp, dpwm_d, aoff_d;
  always_comb begin
    dir_smp = cfg_q.pll_en ? i_pll_tick : dir_tick_q; // R10
    dsh_d = dir_smp ? {dsh_q[`DBC_DIR_STAGES-2:0], sync2_q} : dsh_q; // R11
    dpwm_d = direct && dsh_q[`DBC_DIR_STAGES-1];
    aoff_d = direct && tout_q && sync2_q; // R13
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      dsh_q <= '0;
      o_direct_pwm <= 1'b0;
      o_direct_mode <= 1'b0;
      o_adaptive_off <= 1'b0;
    end else begin
      dsh_q <= dsh_d;
      o_direct_pwm <= dpwm_d;
      o_direct_mode <= direct;
      o_adaptive_off <= aoff_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_dir_rise;
    direct && !cfg_q.pll_en && $rose(sync2_q);
  endsequence
  reg_mode_a: assert property (@(posedge i_clock) disable iff (i_srst) // R8
    cfg_q.mode == MODE_REG |-> tgt == brt_q)
    else $error("Register mode target differs from register.");
  prod_mode_a: assert property (@(posedge i_clock) disable iff (i_srst) // R9
    cfg_q.mode == MODE_PROD |-> tgt == 16'((32'(duty_q) * 32'(brt_q)) >> 16))
    else $error("Product mode target wrong.");
  tout_high_a: assert property (@(posedge i_clock) disable iff (i_srst) // R6
    det_tick_q && tout_q && sync2_q && prev_q |=> duty_q == `DBC_FULL)
    else $error("Timeout with high input did not give full duty.");
  div_load_a: assert property (@(posedge i_clock) disable iff (i_srst) // R3
    st_q == DIV_DONE && !tout_q && !quot_q[16] |=> duty_q == $past(quot_q))
    else $error("Measured duty not taken from divider.");
  dir_lag_a: assert property (@(posedge i_clock) disable iff (i_srst) // R11
    s_dir_rise ##1 (direct && sync2_q) [*8] |->
    ##[80:125] o_direct_pwm)
    else $error("Direct output did not follow input in time.");
  slope_off_a: assert property (@(posedge i_clock) disable iff (i_srst) // R15
    cfg_q.slope_sel == 3'h0 |=> level == $past(tgt))
    else $error("Disabled slope did not jump to target.");
  slope_up_a: assert property (@(posedge i_clock) disable iff (i_srst) // R14
    cfg_q.slope_sel != 3'h0 && !direct && $stable(cfg_q) &&
    {tgt, 16'h0000} > cur_q |=> cur_q >= $past(cur_q))
    else $error("Slope moved away from a higher target.");
  hyb_full_a: assert property (@(posedge i_clock) disable iff (i_srst) // R20
    !direct && cfg_q.hybrid_en && level >= switch_pt(cfg_q.switch_sel)
    |=> o_led_duty == `DBC_FULL)
    else $error("Hybrid duty not full above switch point.");
  dir_bypass_a: assert property (@(posedge i_clock) disable iff (i_srst) // R12
    direct |=> o_led_current == `DBC_FULL && o_led_duty == 16'h0000)
    else $error("Direct mode did not bypass hybrid path.");
endmodule

// ---- testbench/dbc_host_pwm.sv ----
// Host model that drives the brightness PWM pin.
`timescale 1ns/1ns
module dbc_host_pwm (
  // Clock and style
  input wire logic i_clock,
  input wire logic [1:0] i_style,
  input wire logic [15:0] i_high,
  input wire logic [15:0] i_low,
  // Pin
  output logic o_pwm
);
  logic [15:0] cnt_q = 16'h0000;
  logic pwm_q = 1'b0;

  assign o_pwm = pwm_q;

  // Style 0 holds low, 2 holds high, 1 toggles with phases of 40 or more.
  always @(posedge i_clock) begin
    if (i_style != 2'h1) begin
      pwm_q <= (i_style == 2'h2);
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q + 16'h0001 >= (pwm_q ? i_high : i_low) &&
          cnt_q >= 16'h0027) begin
        pwm_q <= !pwm_q;
        cnt_q <= 16'h0000;
      end
    end
  end
endmodule

// ---- testbench/dbc_top_tb_top.sv ----
// Self-checking bench for the display brightness control block.
`timescale 1ns/1ns
`include "dbc_map.svh"
module dbc_top_tb_top;
  logic i_clock, i_srst, i_wr, i_rd;
  logic i_pll_tick = 1'b0;
  logic o_direct_pwm, o_direct_mode, o_adaptive_off;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, o_led_duty, o_led_current, rv;
  logic [1:0] style;
  logic [2:0] pll_cnt = 3'h0;
  wire logic pin;
  int fail_count = 0;
  int comparisons = 0;
  localparam logic [15:0] SW [0:7] = `DBC_SWITCH;
  localparam logic [10:0] GN [0:7] = `DBC_GAIN;

  dbc_top #(.P_TIMEOUT_TICKS(200)) DUT (.i_clock(i_clock),
    .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pwm_in(pin),
    .i_pll_tick(i_pll_tick), .o_led_duty(o_led_duty),
    .o_led_current(o_led_current), .o_direct_pwm(o_direct_pwm),
    .o_direct_mode(o_direct_mode), .o_adaptive_off(o_adaptive_off));

  dbc_host_pwm host (.i_clock(i_clock), .i_style(style),
    .i_high(16'h00C8), .i_low(16'h0258), .o_pwm(pin));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // The stand-in PLL clock ticks once every eight cycles.
  always @(posedge i_clock) begin
    pll_cnt <= pll_cnt + 3'h1;
    i_pll_tick <= (pll_cnt == 3'h3);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // Raises the pin and counts cycles until the direct output follows.
  task automatic lag(input int lo, input int hi);
    int n;
    n = 0;
    @(posedge i_clock);
    style <= 2'h2;
    tick(1);
    while (o_direct_pwm !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk("lag", 16'(n >= lo && n <= hi), 16'h0001);
    if (n >= 200) test_done();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(4'h0, rv);
    chk("ctrl_rst", rv, `DBC_CTRL_RST);
    wr(4'h0, 16'hE001);
    rd(4'h0, rv);
    chk("ctrl", rv, 16'h0001);
    wr(4'h1, 16'h1234);
    rd(4'h1, rv);
    chk("brt", rv, 16'h1234);
    wr(4'h2, 16'h5555);
    rd(4'h2, rv);
    chk("duty_ro", rv, 16'h0000);
    rd(4'hF, rv);
    chk("unmapped", rv, 16'h0000);
    tick(3);
    chk("reg_duty", o_led_duty, 16'h1234);
    chk("reg_cur", o_led_current, 16'hFFFF);
  endtask

  task automatic t_slope;
    logic [15:0] tgt;
    wr(4'h1, 16'h0000);
    for (int c = 1; c <= 2; c++) begin
      wr(4'h0, 16'h0001 | (16'(c) << 2));
      for (int k = 0; k < 2; k++) begin
        tgt = k ? 16'h0000 : 16'h0400;
        wr(4'h1, tgt);
        tick(c * 780);
        rd(4'h3, rv);
        chk("slope_mid", 16'(rv > 0 && rv < 16'h0400), 16'h0001);
        tick(c * 1600);
        rd(4'h3, rv);
        chk("slope_end", rv, tgt);
      end
    end
  endtask

  task automatic t_hybrid;
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, 16'h0021 | (16'(c) << 6) | (16'(c) << 9));
      wr(4'h1, SW[c] >> 1);
      tick(4);
      chk("hyb_duty", 16'(o_led_duty >= 16'h7FFF &&
          o_led_duty <= 16'h8000), 16'h0001);
      chk("hyb_low_cur", o_led_current, 16'h0000);
      wr(4'h1, SW[c] + 16'h1000);
      tick(4);
      chk("hyb_full", o_led_duty, 16'hFFFF);
      chk("hyb_gain", o_led_current, {3'h0, GN[c], 2'h0});
    end
  endtask

  task automatic t_detect;
    wr(4'h0, 16'h0000);
    @(posedge i_clock);
    style <= 2'h1;
    tick(2500);
    chk("in_duty", o_led_duty, 16'h4000);
    rd(4'h2, rv);
    chk("meas", rv, 16'h4000);
    wr(4'h0, 16'h0002);
    wr(4'h1, 16'h8000);
    tick(5);
    chk("product", o_led_duty, 16'h2000);
    wr(4'h0, 16'h0000);
    @(posedge i_clock);
    style <= 2'h2;
    tick(2500);
    chk("to_high", o_led_duty, `DBC_FULL);
    rd(4'h4, rv);
    chk("to_stat", rv, 16'h0001);
    @(posedge i_clock);
    style <= 2'h0;
    tick(2500);
    chk("to_low", o_led_duty, 16'h0000);
  endtask

  task automatic t_direct;
    wr(4'h0, 16'h0003);
    tick(50);
    chk("dir_mode", 16'(o_direct_mode), 16'h0001);
    lag(98, 126);
    chk("dir_duty", o_led_duty, 16'h0000);
    tick(2200);
    chk("adapt_off", 16'(o_adaptive_off), 16'h0001);
    rd(4'h4, rv);
    chk("dir_stat", rv, 16'h0003);
    @(posedge i_clock);
    style <= 2'h0;
    wr(4'h0, 16'h1003);
    tick(300);
    chk("pll_low", 16'(o_direct_pwm), 16'h0000);
    lag(38, 56);
  endtask

  initial begin
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    style = 2'h0;
    repeat (20) @(posedge i_clock);
    i_srst <= 1'b0;
    t_regs();
    t_slope();
    t_hybrid();
    t_detect();
    t_direct();
    test_done();
  end
endmodule
